// ---- core/edge_sync.sv ----
// two-stage synchroniser with rising and falling edge pulses
`timescale 1ns/10ps
`default_nettype none
module edge_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             mclk,
  input  wire logic             rst_n,
  input  wire logic             ce,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] rise,
  output logic      [WIDTH-1:0] fall
);
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;
  logic [WIDTH-1:0] prev_r;

  // first stage feeds only the second one
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '0;
      sync_r <= '0;
      prev_r <= '0;
    end else if (ce) begin
      meta_r <= din;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  assign rise = sync_r & ~prev_r & {WIDTH{ce}};
  assign fall = ~sync_r & prev_r & {WIDTH{ce}};
endmodule
`default_nettype wire

// ---- core/tccu_pkg.sv ----
// constants, field positions and types shared by the capture/compare timer
package tccu_pkg;

  // ----------------------------------------------------------------------
  // register addresses
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_FLAGS    = 8'hC8;
  localparam logic [7:0] ADDR_CTRL     = 8'hEA;
  localparam logic [7:0] ADDR_CAPCTL   = 8'hEB;
  localparam logic [7:0] ADDR_SETEN    = 8'hEE;
  localparam logic [7:0] ADDR_RTEN     = 8'hEF;
  localparam logic [7:0] ADDR_CNT_LO   = 8'hD0;
  localparam logic [7:0] ADDR_CNT_HI   = 8'hD1;
  localparam logic [7:0] ADDR_CAP_BASE = 8'hD2;
  localparam logic [7:0] ADDR_CMP_BASE = 8'hDA;
  localparam logic [7:0] ADDR_PORT     = 8'hE0;
  localparam logic [7:0] CAP_SPAN      = 8'h08;
  localparam logic [7:0] CMP_SPAN      = 8'h06;

  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  localparam int CTRL_SRC_LSB    = 0;
  localparam int CTRL_PRE_LSB    = 2;
  localparam int CTRL_BYTE_FLAG  = 4;
  localparam int CTRL_EXT_RST_EN = 5;
  localparam int CTRL_BYTE_SEL   = 6;
  localparam int CTRL_FULL_SEL   = 7;
  localparam int FLAGS_CAP_LSB   = 0;
  localparam int FLAGS_CMP_LSB   = 4;
  localparam int FLAGS_FULL_OV   = 7;
  localparam int SET_BITS        = 6;
  localparam int TOG_LSB         = 6;

  // ----------------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0]  CTRL_RST   = 8'h00;
  localparam logic [7:0]  CAPCTL_RST = 8'h00;
  localparam logic [7:0]  FLAGS_RST  = 8'h00;
  localparam logic [5:0]  SETEN_RST  = 6'h00;
  localparam logic [7:0]  RTEN_RST   = 8'h00;
  localparam logic [7:0]  PORT_RST   = 8'h00;
  localparam logic [15:0] WORD_RST   = 16'h0000;

  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam int         OSC_DIV     = 12;
  localparam logic [3:0] OSC_DIV_MAX = 4'(OSC_DIV - 1);

  // ----------------------------------------------------------------------
  // synchroniser lanes
  // ----------------------------------------------------------------------
  localparam int SYNC_W   = 6;
  localparam int SYNC_CLK = 4;
  localparam int SYNC_RST = 5;

  // ----------------------------------------------------------------------
  // types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    SRC_HALT = 2'b00,
    SRC_OSC  = 2'b01,
    SRC_TEST = 2'b10,
    SRC_PIN  = 2'b11
  } clk_src_e;

endpackage

// ---- core/timer_capture_compare_unit.sv ----
// 16-bit capture/compare timer with prescaler, match outputs and flags
// ------------------------------------------------------------------------
// Summary of operation
// - prescaler divides by 1, 2, 4 or 8 via control bits 3:2
// - source bits: 00 halt, 01 oscillator/12, 11 pin, 10 test
// - prescaler clears on setting change, source change or counter reset
// - counter not writable; cleared by reset or enabled external edge
// - idle holds counter and prescaler cleared and stopped
// - counter bytes read live, no snapshot latch
// - enabled capture edge copies counter and sets capture flag
// - capture input n uses enables at bits 2n and 2n+1
// - both enables low means no capture and no flag
// - each compare register matching counter sets its compare flag
// - compare 0 match sets enabled port bits 0 to 5
// - compare 1 match clears enabled port bits 0 to 5
// - compare 2 match toggles enabled port bits 6 and 7
// - simultaneous compare 0 and 1 matches clear enabled bits 0 to 5
// - compare registers clear on reset
// - software port access coexists with match actions
// - byte and full overflow share one request, each selectable
// - hardware only sets flags; software clears them
// - flag register layout: overflow 7, compare 6:4, capture 3:0
// - byte overflow flag sits at control bit 4
// - toggle state bits read back the current port bits 6 and 7
// - set-enable bits 6 and 7 are read only
// - reset/toggle enable register gates clear and toggle actions
// ------------------------------------------------------------------------
`timescale 1ns/10ps
`default_nettype none
module timer_capture_compare_unit
  import tccu_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic       ce,
  input  wire logic       idle,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       capture_input_0,
  input  wire logic       capture_input_1,
  input  wire logic       capture_input_2,
  input  wire logic       capture_input_3,
  input  wire logic       counter_external_clock_input,
  input  wire logic       counter_external_reset_input,
  output logic      [7:0] match_output_port,
  output logic            overflow_irq
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  logic [7:0]  ctrl_r;
  logic [7:0]  capctl_r;
  logic [7:0]  flags_r;
  logic [5:0]  seten_r;
  logic [7:0]  rten_r;
  logic [7:0]  port_r;
  logic [3:0]  div_r;
  logic [2:0]  pre_r;
  logic [15:0] cnt_r;
  logic [15:0] cap_r [4];
  logic [15:0] cmp_r [3];
  logic [2:0]  eq_q;
  logic [7:0]  rdata_r;
  logic        irq_r;

  // ----------------------------------------------------------------------
  // input synchronisation
  // ----------------------------------------------------------------------
  logic [SYNC_W-1:0] pin_rise;
  logic [SYNC_W-1:0] pin_fall;

  edge_sync #(.WIDTH(SYNC_W)) u_sync (
    .mclk  (mclk),
    .rst_n (rst_n),
    .ce    (ce),
    .din   ({counter_external_reset_input, counter_external_clock_input,
              capture_input_3, capture_input_2, capture_input_1,
              capture_input_0}),
    .rise  (pin_rise),
    .fall  (pin_fall)
  );

  // ----------------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------------
  wire [7:0] cap_off    = reg_addr - ADDR_CAP_BASE;
  wire [7:0] cmp_off    = reg_addr - ADDR_CMP_BASE;
  wire       cap_in     = cap_off < CAP_SPAN;
  wire       cmp_in     = cmp_off < CMP_SPAN;
  wire       ctrl_wr    = reg_wr && (reg_addr == ADDR_CTRL);
  wire       capctl_wr  = reg_wr && (reg_addr == ADDR_CAPCTL);
  wire       flags_wr   = reg_wr && (reg_addr == ADDR_FLAGS);
  wire       seten_wr   = reg_wr && (reg_addr == ADDR_SETEN);
  wire       rten_wr    = reg_wr && (reg_addr == ADDR_RTEN);
  wire       port_wr    = reg_wr && (reg_addr == ADDR_PORT);
  wire       cmp_wr     = reg_wr && cmp_in;
  wire [1:0] cmp_idx    = cmp_off[2:1];

  // ----------------------------------------------------------------------
  // clock source and prescaler
  // ----------------------------------------------------------------------
  wire       osc_tick   = (div_r == OSC_DIV_MAX);
  wire [1:0] pre_sel    = ctrl_r[CTRL_PRE_LSB +: 2];
  wire [2:0] pre_mask   = {pre_sel == 2'h3, pre_sel[1], pre_sel != 2'h0};
  wire       cfg_change = ctrl_wr && (reg_wdata[3:0] != ctrl_r[3:0]);
  wire       ext_clr    = ctrl_r[CTRL_EXT_RST_EN] && pin_rise[SYNC_RST];
  wire       cnt_clear  = idle || ext_clr;
  clk_src_e  src;
  logic      pre_in;

  assign src = clk_src_e'(ctrl_r[CTRL_SRC_LSB +: 2]);

  always_comb begin
    unique case (src)
      SRC_HALT: pre_in = 1'b0;
      SRC_OSC:  pre_in = osc_tick;
      SRC_TEST: pre_in = 1'b0;
      SRC_PIN:  pre_in = pin_rise[SYNC_CLK];
    endcase
  end

  wire        cnt_step  = pre_in && (pre_r == pre_mask) && !cnt_clear;
  wire [2:0]  pre_nxt   = (cnt_clear || cfg_change || cnt_step) ? 3'h0 :
                          (pre_in ? pre_r + 3'h1 : pre_r);
  wire [15:0] cnt_nxt   = cnt_clear ? WORD_RST :
                          (cnt_step ? cnt_r + 16'h0001 : cnt_r);
  wire        byte_ovf  = cnt_step && (cnt_r[7:0] == 8'hFF);
  wire        full_ovf  = cnt_step && (cnt_r == 16'hFFFF);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      div_r <= 4'h0;
      pre_r <= 3'h0;
      cnt_r <= WORD_RST;
    end else if (ce) begin
      div_r <= osc_tick ? 4'h0 : div_r + 4'h1;
      pre_r <= pre_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // capture
  // ----------------------------------------------------------------------
  logic [3:0] cap_hit;

  for (genvar n = 0; n < 4; n++) begin : g_cap
    assign cap_hit[n] = (pin_rise[n] && capctl_r[2*n]) ||
                        (pin_fall[n] && capctl_r[2*n+1]);
    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        cap_r[n] <= WORD_RST;
      end else if (ce && cap_hit[n]) begin
        cap_r[n] <= cnt_r;
      end
    end
  end

  // ----------------------------------------------------------------------
  // compare
  // ----------------------------------------------------------------------
  logic [2:0] eq_now;
  logic [2:0] cmp_hit;

  for (genvar i = 0; i < 3; i++) begin : g_cmp
    // edge of equality so a slow counter acts only once per match
    assign eq_now[i]  = (cnt_r == cmp_r[i]);
    assign cmp_hit[i] = eq_now[i] && !eq_q[i];
    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        cmp_r[i] <= WORD_RST;
      end else if (ce && cmp_wr && (cmp_idx == 2'(i))) begin
        if (cmp_off[0]) begin
          cmp_r[i][15:8] <= reg_wdata;
        end else begin
          cmp_r[i][7:0] <= reg_wdata;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // match output port
  // ----------------------------------------------------------------------
  wire [7:0] port_base = port_wr ? reg_wdata : port_r;
  wire [7:0] set_mask  = {2'b00, seten_r} & {8{cmp_hit[0]}};
  wire [7:0] clr_mask  = {2'b00, rten_r[5:0]} & {8{cmp_hit[1]}};
  wire [7:0] tog_mask  = {rten_r[7:6], 6'h00} & {8{cmp_hit[2]}};
  // clear applied after set, so a double match leaves the bits low
  wire [7:0] port_nxt  = ((port_base | set_mask) & ~clr_mask) ^ tog_mask;

  // ----------------------------------------------------------------------
  // flags, software writes only clear
  // ----------------------------------------------------------------------
  wire [7:0] flags_set = {full_ovf, cmp_hit, cap_hit};
  wire [7:0] flags_keep = flags_wr ? (flags_r & reg_wdata) : flags_r;
  wire [7:0] flags_nxt = flags_keep | flags_set;
  wire       bflag_keep = ctrl_wr ? (ctrl_r[CTRL_BYTE_FLAG] & reg_wdata[CTRL_BYTE_FLAG])
                                  : ctrl_r[CTRL_BYTE_FLAG];
  wire       bflag_nxt = bflag_keep | byte_ovf;
  wire [7:0] ctrl_base = ctrl_wr ? reg_wdata : ctrl_r;
  wire [7:0] ctrl_nxt  = {ctrl_base[7:5], bflag_nxt, ctrl_base[3:0]};
  wire       irq_nxt   = (ctrl_r[CTRL_BYTE_FLAG] && ctrl_r[CTRL_BYTE_SEL]) ||
                         (flags_r[FLAGS_FULL_OV] && ctrl_r[CTRL_FULL_SEL]);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r   <= CTRL_RST;
      capctl_r <= CAPCTL_RST;
      flags_r  <= FLAGS_RST;
      seten_r  <= SETEN_RST;
      rten_r   <= RTEN_RST;
      port_r   <= PORT_RST;
      eq_q     <= 3'h0;
      irq_r    <= 1'b0;
    end else if (ce) begin
      ctrl_r   <= ctrl_nxt;
      capctl_r <= capctl_wr ? reg_wdata : capctl_r;
      flags_r  <= flags_nxt;
      seten_r  <= seten_wr ? reg_wdata[SET_BITS-1:0] : seten_r;
      rten_r   <= rten_wr ? reg_wdata : rten_r;
      port_r   <= port_nxt;
      eq_q     <= eq_now;
      irq_r    <= irq_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------------
  logic [7:0]  rd_mux;
  wire  [15:0] cap_word = cap_r[cap_off[2:1]];
  wire  [15:0] cmp_word = (cmp_idx == 2'h3) ? WORD_RST : cmp_r[cmp_idx];

  always_comb begin
    rd_mux = 8'h00;
    if (cap_in) begin
      rd_mux = cap_off[0] ? cap_word[15:8] : cap_word[7:0];
    end else if (cmp_in) begin
      rd_mux = cmp_off[0] ? cmp_word[15:8] : cmp_word[7:0];
    end else begin
      case (reg_addr)
        ADDR_FLAGS:  rd_mux = flags_r;
        ADDR_CTRL:   rd_mux = ctrl_r;
        ADDR_CAPCTL: rd_mux = capctl_r;
        ADDR_SETEN:  rd_mux = {port_r[7:TOG_LSB], seten_r};
        ADDR_RTEN:   rd_mux = rten_r;
        ADDR_PORT:   rd_mux = port_r;
        ADDR_CNT_LO: rd_mux = cnt_r[7:0];
        ADDR_CNT_HI: rd_mux = cnt_r[15:8];
        default:     rd_mux = 8'h00;
      endcase
    end
  end

  // data only in the cycle after the strobe, zero otherwise
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= 8'h00;
    end else if (ce) begin
      rdata_r <= reg_rd ? rd_mux : 8'h00;
    end
  end

  assign reg_rdata         = rdata_r;
  assign match_output_port = port_r;
  assign overflow_irq      = irq_r;

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  a_halt_holds: assert property (
    ce && src == SRC_HALT && !cnt_clear |=> cnt_r == $past(cnt_r))
    else $error("counter moved while halted");

  a_div_by_two: assert property (
    ce && pre_in && pre_sel == 2'h1 && pre_r == 3'h0 && !cnt_clear && !cfg_change
    |=> pre_r == 3'h1 && cnt_r == $past(cnt_r))
    else $error("divide by two stepped early");

  a_cfg_clears: assert property (
    ce && cfg_change |=> pre_r == 3'h0)
    else $error("prescaler not cleared on setting change");

  a_ext_reset: assert property (
    ce && ctrl_r[CTRL_EXT_RST_EN] && pin_rise[SYNC_RST] |=> cnt_r == 16'h0000)
    else $error("external reset ignored");

  a_idle_clear: assert property (
    (ce && idle)[*2] |-> cnt_r == 16'h0000 && pre_r == 3'h0)
    else $error("idle did not hold counter cleared");

  a_capture_copy: assert property (
    ce && cap_hit[0] |=> cap_r[0] == $past(cnt_r) && flags_r[0])
    else $error("capture 0 did not copy counter");

  a_no_capture: assert property (
    ce && capctl_r[5:4] == 2'b00 |=> cap_r[2] == $past(cap_r[2]) && !$rose(flags_r[2]))
    else $error("disabled capture acted");

  a_cmp_flag: assert property (
    ce && cmp_hit[1] |=> flags_r[5])
    else $error("compare 1 flag not set");

  a_reset_wins: assert property (
    ce && cmp_hit[0] && cmp_hit[1] |=> (port_r[5:0] & $past(rten_r[5:0])) == 6'h00)
    else $error("reset did not win over set");

  a_toggle_bit7: assert property (
    ce && cmp_hit[2] && rten_r[7] && !port_wr |=> port_r[7] != $past(port_r[7]))
    else $error("bit 7 did not toggle");

  a_set_action: assert property (
    ce && cmp_hit[0] && !cmp_hit[1] |=> (port_r[5:0] & $past(seten_r)) == $past(seten_r))
    else $error("enabled port bits not set");

  a_flag_sticky: assert property (
    ce && flags_r[FLAGS_FULL_OV] && !flags_wr |=> flags_r[FLAGS_FULL_OV])
    else $error("overflow flag cleared by hardware");

  a_irq_request: assert property (
    (ce && flags_r[FLAGS_FULL_OV] && ctrl_r[CTRL_FULL_SEL])[*2] |-> overflow_irq)
    else $error("overflow request missing");

  a_byte_request: assert property (
    (ce && ctrl_r[CTRL_BYTE_FLAG] && ctrl_r[CTRL_BYTE_SEL])[*2] |-> overflow_irq)
    else $error("byte overflow request missing");

  c_capture:  cover property (ce && cap_hit[0]);
  c_toggle:   cover property (ce && cmp_hit[2] && rten_r[7]);
  c_full_ovf: cover property (ce && full_ovf);
  c_dbl_hit:  cover property (ce && cmp_hit[0] && cmp_hit[1]);

endmodule
`default_nettype wire

// ---- dv/pin_partner.sv ----
// far-side pin model: capture pins, external clock, external reset, port watch
`timescale 1ns/10ps
`default_nettype none
module pin_partner (
  input  wire logic       mclk,
  input  wire logic [7:0] match_output_port,
  output logic      [3:0] cap_pin,
  output logic            ext_clk,
  output logic            ext_rst
);
  logic [7:0] seen;

  // ----------------------------------------------------------------------
  // pins
  // ----------------------------------------------------------------------
  initial begin
    cap_pin = 4'h0;
    ext_clk = 1'b0;
    ext_rst = 1'b0;
  end

  // registered copy of the port, as a load on the pins would see it
  always @(posedge mclk) begin
    seen <= match_output_port;
  end

  // levels held for several cycles so two sync flops always catch them
  task automatic set_caps(input logic [3:0] v);
    @(posedge mclk);
    cap_pin <= v;
    repeat (6) @(posedge mclk);
  endtask

  // clock stands low between bursts, never free running
  task automatic clocks(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge mclk);
      ext_clk <= 1'b1;
      repeat (3) @(posedge mclk);
      ext_clk <= 1'b0;
      repeat (3) @(posedge mclk);
    end
  endtask

  task automatic reset_pulse();
    @(posedge mclk);
    ext_rst <= 1'b1;
    repeat (3) @(posedge mclk);
    ext_rst <= 1'b0;
    repeat (4) @(posedge mclk);
  endtask
endmodule
`default_nettype wire

// ---- dv/tb.sv ----
// self-checking bench for the capture/compare timer
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, gt) \
  begin \
    checked++; \
    if ((gt) !== (ex)) begin \
      miscompares++; \
      $display("ERROR %s expected %h seen %h", nm, ex, gt); \
    end \
  end
module tb;
  import tccu_pkg::*;
  logic       mclk;
  logic       rst_n;
  logic       ce;
  logic       idle;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_rdata;
  logic [3:0] cap_pin;
  logic       ext_clk;
  logic       ext_rst;
  logic [7:0] port;
  logic       ovf_irq;
  logic [7:0] a;
  logic [7:0] c;
  int         miscompares;
  int         checked;
  logic [7:0] rst_map [8] = '{ADDR_CTRL, ADDR_CAPCTL, ADDR_SETEN, ADDR_RTEN, ADDR_PORT,
                              ADDR_CNT_LO, ADDR_CNT_HI, 8'hFF};

  timer_capture_compare_unit i_dut (
    .mclk                         (mclk),
    .rst_n                        (rst_n),
    .ce                           (ce),
    .idle                         (idle),
    .reg_addr                     (reg_addr),
    .reg_wdata                    (reg_wdata),
    .reg_wr                       (reg_wr),
    .reg_rd                       (reg_rd),
    .reg_rdata                    (reg_rdata),
    .capture_input_0              (cap_pin[0]),
    .capture_input_1              (cap_pin[1]),
    .capture_input_2              (cap_pin[2]),
    .capture_input_3              (cap_pin[3]),
    .counter_external_clock_input (ext_clk),
    .counter_external_reset_input (ext_rst),
    .match_output_port            (port),
    .overflow_irq                 (ovf_irq)
  );

  pin_partner i_far (
    .mclk              (mclk),
    .match_output_port (port),
    .cap_pin           (cap_pin),
    .ext_clk           (ext_clk),
    .ext_rst           (ext_rst)
  );

  // ----------------------------------------------------------------------
  // bus tasks
  // ----------------------------------------------------------------------
  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    @(posedge mclk);
    reg_addr  <= ad;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  // takes two edges, returns at the falling edge with the data settled
  task automatic rd(input logic [7:0] ad, output logic [7:0] d);
    @(posedge mclk);
    reg_addr <= ad;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    d = reg_rdata;
  endtask

  task automatic expect_rd(input string nm, input logic [7:0] ad, input logic [7:0] ex);
    logic [7:0] d;
    rd(ad, d);
    `CHK(nm, ex, d)
  endtask

  // live counter reads a fixed number of edges apart
  task automatic rate(input logic [7:0] ctl, input int gap, input logic [7:0] steps);
    logic [7:0] b;
    wr(ADDR_CTRL, ctl);
    rd(ADDR_CNT_LO, a);
    repeat (gap - 2) @(posedge mclk);
    rd(ADDR_CNT_LO, b);
    `CHK("counter steps", steps, 8'(b - a))
  endtask

  task automatic conclude();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // clock, watchdog, sequence
  // ----------------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // a hang anywhere counts as a mismatch
  initial begin
    #400000;
    miscompares++;
    conclude();
  end

  initial begin
    rst_n       = 1'b0;
    ce          = 1'b1;
    idle        = 1'b0;
    reg_addr    = 8'h00;
    reg_wdata   = 8'h00;
    reg_wr      = 1'b0;
    reg_rd      = 1'b0;
    miscompares = 0;
    checked     = 0;
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    foreach (rst_map[i]) expect_rd("reset value", rst_map[i], 8'h00);
    for (int i = 0; i < 14; i++) expect_rd("reset word", ADDR_CAP_BASE + 8'(i), 8'h00);
    `CHK("port reset", PORT_RST, i_far.seen)
    for (int p = 0; p < 4; p++) rate({4'h0, 2'(p), 2'b01}, 96 << p, 8'h08);
    rate(8'h00, 96, 8'h00);
    rate(8'h02, 96, 8'h00);
    rate(8'h03, 2, 8'h00);
    i_far.clocks(5);
    expect_rd("pin clock", ADDR_CNT_LO, a + 8'h05);
    wr(ADDR_CTRL, 8'h07);
    i_far.clocks(1);
    wr(ADDR_CTRL, 8'h0B);
    wr(ADDR_CTRL, 8'h07);
    i_far.clocks(1);
    expect_rd("pre cleared", ADDR_CNT_LO, a + 8'h05);
    wr(ADDR_CTRL, 8'h00);
    rd(ADDR_CNT_LO, a);
    rd(ADDR_CNT_HI, c);
    // capture: in0 rising, in1 falling, in2 off, in3 both
    wr(ADDR_CAPCTL, 8'hC9);
    wr(ADDR_FLAGS, 8'h00);
    i_far.set_caps(4'hF);
    expect_rd("rise flags", ADDR_FLAGS, 8'h09);
    expect_rd("cap0 lo", ADDR_CAP_BASE, a);
    expect_rd("cap0 hi", ADDR_CAP_BASE + 8'h01, c);
    expect_rd("cap3 lo", ADDR_CAP_BASE + 8'h06, a);
    wr(ADDR_FLAGS, 8'hFE);
    expect_rd("flag clear", ADDR_FLAGS, 8'h08);
    i_far.set_caps(4'h0);
    expect_rd("fall flags", ADDR_FLAGS, 8'h0A);
    expect_rd("cap1 lo", ADDR_CAP_BASE + 8'h02, a);
    expect_rd("cap2 idle", ADDR_CAP_BASE + 8'h04, 8'h00);
    wr(ADDR_CNT_LO, ~a);
    expect_rd("no load", ADDR_CNT_LO, a);
    i_far.reset_pulse();
    expect_rd("reset off", ADDR_CNT_LO, a);
    wr(ADDR_CTRL, 8'h01);
    repeat (40) @(posedge mclk);
    idle <= 1'b1;
    repeat (30) @(posedge mclk);
    expect_rd("idle lo", ADDR_CNT_LO, 8'h00);
    expect_rd("idle hi", ADDR_CNT_HI, 8'h00);
    @(posedge mclk);
    idle <= 1'b0;
    wr(ADDR_CTRL, 8'h21);
    repeat (40) @(posedge mclk);
    wr(ADDR_CTRL, 8'h20);
    i_far.reset_pulse();
    expect_rd("pin reset lo", ADDR_CNT_LO, 8'h00);
    expect_rd("pin reset hi", ADDR_CNT_HI, 8'h00);
    // compare: set at 5, toggle at 7, clear at 9
    wr(ADDR_CMP_BASE, 8'h05);
    wr(ADDR_CMP_BASE + 8'h02, 8'h09);
    wr(ADDR_CMP_BASE + 8'h04, 8'h07);
    wr(ADDR_SETEN, 8'h15);
    wr(ADDR_RTEN, 8'h85);
    wr(ADDR_PORT, 8'h00);
    wr(ADDR_FLAGS, 8'h00);
    wr(ADDR_CTRL, 8'h21);
    repeat (150) @(posedge mclk);
    wr(ADDR_CTRL, 8'h20);
    repeat (2) @(posedge mclk);
    `CHK("match port", 8'h90, i_far.seen)
    expect_rd("cmp flags", ADDR_FLAGS, 8'h70);
    expect_rd("port read", ADDR_PORT, 8'h90);
    expect_rd("toggle state", ADDR_SETEN, 8'h95);
    // simultaneous set and clear on bits 5:0
    rd(ADDR_CNT_LO, a);
    wr(ADDR_CMP_BASE, a + 8'h02);
    wr(ADDR_CMP_BASE + 8'h02, a + 8'h02);
    wr(ADDR_SETEN, 8'h3F);
    wr(ADDR_RTEN, 8'h3F);
    wr(ADDR_PORT, 8'hBF);
    repeat (2) @(posedge mclk);
    `CHK("port write", 8'hBF, i_far.seen)
    wr(ADDR_CTRL, 8'h21);
    repeat (40) @(posedge mclk);
    wr(ADDR_CTRL, 8'h20);
    repeat (2) @(posedge mclk);
    `CHK("clear wins", 8'h80, i_far.seen)
    // byte overflow through the shared request
    wr(ADDR_CTRL, 8'h41);
    repeat (3200) @(posedge mclk);
    wr(ADDR_CTRL, 8'h50);
    repeat (2) @(posedge mclk);
    `CHK("byte irq", 1'b1, ovf_irq)
    expect_rd("byte flag", ADDR_CTRL, 8'h50);
    wr(ADDR_CTRL, 8'h10);
    repeat (2) @(posedge mclk);
    `CHK("irq gated", 1'b0, ovf_irq)
    wr(ADDR_CTRL, 8'h40);
    wr(ADDR_CTRL, 8'h50);
    expect_rd("no soft set", ADDR_CTRL, 8'h40);
    `CHK("irq cleared", 1'b0, ovf_irq)
    wr(ADDR_SETEN, 8'hFF);
    expect_rd("seten ro", ADDR_SETEN, 8'hBF);
    conclude();
  end
endmodule
`default_nettype wire
